// ===== verilog/hdlc_address_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "hdlc_addr_map.vh"
// Contract
// [R1] tx address fields apply only in automode, address mode 1, non-automode.
// [R2] programmed tx address byte(s) are inserted into each outgoing frame.
// [R3] insertion depends on sub-mode and on the address field size bit.
// [R4] two-byte field: second tx address field is the low byte.
// [R5] two-byte field: first tx address field is the high byte.
// [R6] software writes bit 1 of the first tx field as zero in two-byte use.
// [R7] tx bit 1 follows indication: set means commands 1, responses 0.
// [R8] one-byte field: second tx field addresses response frames.
// [R9] one-byte field: first tx field addresses command frames.
// [R10] with recognition, received high and low bytes are compared to programmed.
// [R11] comparison may be masked per bit in every recognising sub-mode.
// [R12] masked bit always matches; unmasked bit must match exactly.
// [R13] automode: bit 1 of first rx high byte is the indication control.
// [R14] status c/r: indication set means command 0, response 1.
// [R15] software zeroes first rx high byte for one-byte automode.
// [R16] 16-bit auto/non-auto: first rx low byte is first low address.
// [R17] 8-bit auto/non-auto: first rx low byte identifies command frames.
// [R18] second rx high and low bytes form a second address.
// [R19] one-byte field: second rx low byte identifies response frames.
// [R20] frame accepted if either address matches, else discarded.
module hdlc_address_unit (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        tx_req,
	input  wire        tx_is_command,
	output reg         tx_addr_valid,
	output reg         tx_addr_insert,
	output reg         tx_addr_two,
	output reg  [7:0]  tx_addr_high,
	output reg  [7:0]  tx_addr_low,
	input  wire        rx_addr_valid,
	input  wire [7:0]  rx_addr_byte0,
	input  wire [7:0]  rx_addr_byte1,
	output reg         rx_result_valid,
	output reg         rx_accept,
	output reg         rx_match_second,
	output reg  [7:0]  rx_status_byte
);
	// ----------------------------------------
	// register storage
	// ----------------------------------------
	reg  [15:0] transmit_address;
	reg  [31:0] receive_address;
	reg  [31:0] rx_addr_mask;
	reg  [2:0]  config_bits;

	wire [1:0] sub_mode = config_bits[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
	// set selects the two-byte address field
	wire       addr_field_size_select = config_bits[`CFG_SIZE_BIT];

	wire [7:0] tx_addr_first  = transmit_address[7:0];
	wire [7:0] tx_addr_second = transmit_address[15:8];
	wire [7:0] rx_addr_first_high  = receive_address[31:24];
	wire [7:0] rx_addr_first_low   = receive_address[23:16];
	wire [7:0] rx_addr_second_high = receive_address[15:8];
	wire [7:0] rx_addr_second_low  = receive_address[7:0];
	wire       cmd_resp_indication = rx_addr_first_high[`CR_BIT]; // [R13]

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	function known;
		input [11:0] a;
		begin
			known = (a == `OFS_CONFIG) || (a == `OFS_STATUS) ||
			        (a == `OFS_TX_ADDR) || (a == `OFS_RX_ADDR) ||
			        (a == `OFS_RX_MASK);
		end
	endfunction

	// ----------------------------------------
	// axi4-lite write path
	// ----------------------------------------
	// address and data are held until both have arrived
	reg [11:0] aw_hold;
	reg        aw_have;
	reg [31:0] w_hold;
	reg [3:0]  ws_hold;
	reg        w_have;

	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire  = s_axi_wvalid && s_axi_wready;
	wire [11:0] wa = aw_fire ? s_axi_awaddr : aw_hold;
	wire [31:0] wd = w_fire ? s_axi_wdata : w_hold;
	wire [3:0]  ws = w_fire ? s_axi_wstrb : ws_hold;
	wire wa_ok = aw_have || aw_fire;
	wire wd_ok = w_have || w_fire;
	wire do_write = wa_ok && wd_ok && !s_axi_bvalid;
	wire [11:0] wa_word = {wa[11:2], 2'b00};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_have       <= 1'b0;
			w_have        <= 1'b0;
			aw_hold       <= 12'h000;
			w_hold        <= 32'h00000000;
			ws_hold       <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_hold <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_hold  <= s_axi_wdata;
				ws_hold <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have      <= 1'b0;
				w_have       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= known(wa_word[11:0]) ?
				                `RESP_OKAY : `RESP_SLVERR;
			end else begin
				if (aw_fire)
					aw_have <= 1'b1;
				if (w_fire)
					w_have <= 1'b1;
				if (s_axi_bvalid && s_axi_bready)
					s_axi_bvalid <= 1'b0;
			end
			s_axi_awready <= !s_axi_awready && !aw_have && !aw_fire &&
			                 !s_axi_bvalid && !do_write;
			s_axi_wready  <= !s_axi_wready && !w_have && !w_fire &&
			                 !s_axi_bvalid && !do_write;
		end
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	reg [31:0] next_merge;
	always @* begin
		next_merge = 32'h00000000;
		case (wa_word[11:0])
			`OFS_CONFIG:  next_merge = merge({29'h0, config_bits}, wd, ws);
			`OFS_TX_ADDR: next_merge = merge({16'h0, transmit_address}, wd, ws);
			`OFS_RX_ADDR: next_merge = merge(receive_address, wd, ws);
			`OFS_RX_MASK: next_merge = merge(rx_addr_mask, wd, ws);
			default:      next_merge = 32'h00000000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			transmit_address <= `RST_TX_ADDR;
			receive_address  <= `RST_RX_ADDR;
			rx_addr_mask     <= `RST_RX_MASK;
			config_bits      <= `RST_CONFIG;
		end else if (do_write) begin
			case (wa_word[11:0])
				`OFS_CONFIG:  config_bits      <= next_merge[2:0];
				`OFS_TX_ADDR: transmit_address <= next_merge[15:0];
				`OFS_RX_ADDR: receive_address  <= next_merge;
				`OFS_RX_MASK: rx_addr_mask     <= next_merge;
				default:      config_bits      <= config_bits;
			endcase
		end
	end

	// ----------------------------------------
	// axi4-lite read path
	// ----------------------------------------
	reg [31:0] next_rdata;
	always @* begin
		next_rdata = 32'h00000000;
		case ({s_axi_araddr[11:2], 2'b00})
			`OFS_CONFIG:  next_rdata = {29'h0, config_bits};
			`OFS_STATUS:  next_rdata = {24'h0, rx_status_byte};
			`OFS_TX_ADDR: next_rdata = {16'h0, transmit_address};
			`OFS_RX_ADDR: next_rdata = receive_address;
			`OFS_RX_MASK: next_rdata = rx_addr_mask;
			default:      next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= known({s_axi_araddr[11:2], 2'b00}) ?
				                `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
			                 !(s_axi_arvalid && s_axi_arready);
		end
	end

	// ----------------------------------------
	// transmit address insertion
	// ----------------------------------------
	wire tx_handled = (sub_mode == `MODE_AUTO) ||
	                  (sub_mode == `MODE_ADDR1) ||
	                  (sub_mode == `MODE_NONAUTO); // [R1]
	// c/r polarity: set indication sends 1 in commands
	wire tx_cr = tx_is_command ? cmd_resp_indication
	                           : ~cmd_resp_indication; // [R7]
	// bit 1 is overwritten, so a stray one in the field does no harm
	wire [7:0] tx_high16 = {tx_addr_first[7:2], tx_cr,
	                        tx_addr_first[0]}; // [R5] [R6] [R7]

	always @(posedge aclk) begin
		if (!aresetn) begin
			tx_addr_valid  <= 1'b0;
			tx_addr_insert <= 1'b0;
			tx_addr_two    <= 1'b0;
			tx_addr_high   <= 8'h00;
			tx_addr_low    <= 8'h00;
		end else begin
			tx_addr_valid <= tx_req;
			if (tx_req) begin
				tx_addr_insert <= tx_handled; // [R1] [R2]
				tx_addr_two    <= addr_field_size_select; // [R3]
				if (addr_field_size_select) begin
					tx_addr_high <= tx_high16; // [R5]
					tx_addr_low  <= tx_addr_second; // [R4]
				end else begin
					tx_addr_high <= tx_is_command ? tx_addr_first // [R9]
					                              : tx_addr_second; // [R8]
					tx_addr_low  <= 8'h00;
				end
			end
		end
	end

	// ----------------------------------------
	// receive address recognition
	// ----------------------------------------
	// lanes: 0 first high, 1 first low, 2 second high, 3 second low
	wire [31:0] rx_prog = receive_address;
	wire [31:0] rx_mask;
	// automode keeps the indication bit out of the compare
	assign rx_mask[31:24] = rx_addr_mask[15:8] |
	        ((sub_mode == `MODE_AUTO) ? 8'h02 : 8'h00); // [R13]
	assign rx_mask[23:16] = rx_addr_mask[7:0];
	assign rx_mask[15:8]  = rx_addr_mask[31:24];
	assign rx_mask[7:0]   = rx_addr_mask[23:16];

	wire [31:0] rx_seen;
	// two-byte: first byte against high, second against low
	// one-byte: the single byte meets the low (or mode 1 high) fields
	wire [7:0] one_byte_val = rx_addr_byte0;
	assign rx_seen[31:24] = addr_field_size_select ? rx_addr_byte0
	                                               : one_byte_val;
	assign rx_seen[23:16] = addr_field_size_select ? rx_addr_byte1
	                                               : one_byte_val;
	assign rx_seen[15:8]  = rx_seen[31:24];
	assign rx_seen[7:0]   = rx_seen[23:16];

	wire [3:0] lane_hit;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			masked_match #(
				.WIDTH      (8)
			) u_match (
				.rx_value   (rx_seen[31-8*g -: 8]),
				.programmed (rx_prog[31-8*g -: 8]),
				.mask       (rx_mask[31-8*g -: 8]),
				.hit        (lane_hit[g])
			); // [R10] [R11] [R12]
		end
	endgenerate

	reg hit_first;
	reg hit_second;
	always @* begin
		hit_first  = 1'b0;
		hit_second = 1'b0;
		if (sub_mode == `MODE_ADDR1) begin
			hit_first  = lane_hit[0];
			hit_second = lane_hit[2];
		end else if (addr_field_size_select) begin
			hit_first  = lane_hit[0] & lane_hit[1]; // [R10] [R16]
			hit_second = lane_hit[2] & lane_hit[3]; // [R18]
		end else begin
			hit_first  = lane_hit[1]; // [R17]
			hit_second = lane_hit[3]; // [R19]
		end
	end

	wire rx_recognise = (sub_mode != `MODE_TRANSP);
	wire rx_hit = hit_first | hit_second;
	// one-byte: command frames hit the first low field (the first high field in mode 1)
	wire one_is_cmd = hit_first;
	wire rx_cr_one = one_is_cmd ? ~cmd_resp_indication
	                            : cmd_resp_indication; // [R14]
	wire rx_cr = addr_field_size_select ? rx_addr_byte0[`CR_BIT]
	                                    : rx_cr_one; // [R14]

	always @(posedge aclk) begin
		if (!aresetn) begin
			rx_result_valid <= 1'b0;
			rx_accept       <= 1'b0;
			rx_match_second <= 1'b0;
			rx_status_byte  <= 8'h00;
		end else begin
			rx_result_valid <= rx_addr_valid;
			if (rx_addr_valid) begin
				rx_accept       <= !rx_recognise || rx_hit; // [R20]
				rx_match_second <= rx_recognise && !hit_first &&
				                   hit_second;
				rx_status_byte  <= 8'h00;
				rx_status_byte[`ST_CR_BIT]     <= rx_cr; // [R14]
				rx_status_byte[`ST_ACCEPT_BIT] <= !rx_recognise || rx_hit;
				rx_status_byte[`ST_SECOND_BIT] <= rx_recognise &&
				                                  !hit_first && hit_second;
				rx_status_byte[`ST_VALID_BIT]  <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verilog/hdlc_addr_map.vh
`ifndef HDLC_ADDR_MAP_VH
`define HDLC_ADDR_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CONFIG         12'h100
`define OFS_STATUS         12'h104
`define OFS_TX_ADDR        12'h134
`define OFS_RX_ADDR        12'h138
`define OFS_RX_MASK        12'h13C
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_TX_ADDR        16'h0000
`define RST_RX_ADDR        32'h00000000
`define RST_RX_MASK        32'h00000000
`define RST_CONFIG         3'h0
// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_MODE_LSB       0
`define CFG_SIZE_BIT       2
`define CR_BIT             1
`define ST_CR_BIT          0
`define ST_ACCEPT_BIT      1
`define ST_SECOND_BIT      2
`define ST_VALID_BIT       3
// ----------------------------------------
// sub-mode codes
// ----------------------------------------
`define MODE_AUTO          2'h0
`define MODE_ADDR1         2'h1
`define MODE_NONAUTO       2'h2
`define MODE_TRANSP        2'h3
// ----------------------------------------
// bus answers
// ----------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// ===== verilog/masked_match.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// masked address compare
// ----------------------------------------
module masked_match #(
	parameter WIDTH = 8
) (
	input  wire [WIDTH-1:0] rx_value,
	input  wire [WIDTH-1:0] programmed,
	input  wire [WIDTH-1:0] mask,
	output wire             hit
);
	// a set mask bit always matches
	assign hit = &((~(rx_value ^ programmed)) | mask); // [R12]
endmodule
`default_nettype wire

// ===== testbench/hdlc_address_unit_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module hdlc_address_unit_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       tx_req,
	input wire logic       tx_is_command,
	input wire logic       tx_addr_valid,
	input wire logic       tx_addr_insert,
	input wire logic       tx_addr_two,
	input wire logic [7:0] tx_addr_high,
	input wire logic [7:0] tx_addr_low,
	input wire logic       rx_addr_valid,
	input wire logic       rx_result_valid,
	input wire logic       rx_accept,
	input wire logic       rx_match_second,
	input wire logic [7:0] rx_status_byte
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_cmd_then_resp;
		tx_req && tx_is_command ##1 tx_req && !tx_is_command;
	endsequence
	sequence s_rx_done;
		rx_addr_valid ##1 rx_result_valid;
	endsequence
	a_tx_answer: assert property (tx_req |=> tx_addr_valid)
		else $error("tx address missing after request");
	a_tx_no_extra: assert property (!tx_req |=> !tx_addr_valid)
		else $error("tx address without request");
	// with two-byte insertion, command and response one cycle apart must carry opposite c/r bits
	a_cr_flips: assert property (s_cmd_then_resp ##1 tx_addr_two &&
		tx_addr_insert |-> tx_addr_high[1] != $past(tx_addr_high[1]))
		else $error("c/r bit equal for command and response");
	a_one_byte_low: assert property (tx_addr_valid && !tx_addr_two
		|-> tx_addr_low == 8'h00) else $error("low byte set in one-byte");
	a_rx_answer: assert property (rx_addr_valid |=> rx_result_valid)
		else $error("rx result missing");
	a_rx_no_extra: assert property (!rx_addr_valid |=> !rx_result_valid)
		else $error("rx result without address");
	a_status_acc: assert property (s_rx_done |-> rx_status_byte[3] &&
		rx_status_byte[1] == rx_accept) else $error("status accept wrong");
	a_second_acc: assert property (rx_result_valid && rx_match_second
		|-> rx_accept && rx_status_byte[2]) else $error("second not accepted");
	a_accept_stands: assert property ($changed(rx_accept)
		|-> rx_result_valid) else $error("accept moved between results");
endmodule
`default_nettype wire

// ===== testbench/remote_station.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// far station: hands over received addresses
// ----------------------------------------
module remote_station (
	input  wire logic       aclk,
	output var  logic       rx_addr_valid,
	output var  logic [7:0] rx_addr_byte0,
	output var  logic [7:0] rx_addr_byte1
);
	initial begin
		rx_addr_valid = 1'h0;
		rx_addr_byte0 = 8'hA5;
		rx_addr_byte1 = 8'h5A;
	end
	task send(input logic [7:0] x0, input logic [7:0] x1);
		@(posedge aclk);
		rx_addr_valid <= 1'h1;
		rx_addr_byte0 <= x0;
		rx_addr_byte1 <= x1;
		@(posedge aclk);
		rx_addr_valid <= 1'h0;
		// bytes are not held after the frame, so never leave them valid-looking
		rx_addr_byte0 <= ~x0;
		rx_addr_byte1 <= ~x1;
	endtask
endmodule
`default_nettype wire

// ===== testbench/tb_hdlc_address_unit.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module tb_hdlc_address_unit;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, tx_req, tx_cmd;
	logic        tx_valid, tx_ins, tx_two, rx_valid, rx_done, rx_acc, rx_sec;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, seed, cfg, txa, rxa, mk, rv, r;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  tx_hi, tx_lo, b0, b1, rx_st, x0, x1;
	logic [2:0]  e;
	logic [3:0]  wstrb;
	integer      err_total, compares, i, j;
	hdlc_address_unit u_dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_req(tx_req),
		.tx_is_command(tx_cmd), .tx_addr_valid(tx_valid),
		.tx_addr_insert(tx_ins), .tx_addr_two(tx_two), .tx_addr_high(tx_hi),
		.tx_addr_low(tx_lo), .rx_addr_valid(rx_valid), .rx_addr_byte0(b0),
		.rx_addr_byte1(b1), .rx_result_valid(rx_done), .rx_accept(rx_acc),
		.rx_match_second(rx_sec), .rx_status_byte(rx_st)
	);
	remote_station u_peer (.aclk(aclk), .rx_addr_valid(rx_valid),
		.rx_addr_byte0(b0), .rx_addr_byte1(b1));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic eq(input logic [7:0] a, p, m);
		return ((a ^ p) & ~m) == 8'h00;
	endfunction
	function automatic logic [16:0] tx_exp(input logic c);
		if (cfg[2])
			return {1'h1, txa[7:2], c ? rxa[25] : ~rxa[25], txa[0], txa[15:8]};
		return {1'h0, c ? txa[7:0] : txa[15:8], 8'h00};
	endfunction
	function automatic logic [2:0] rx_exp(input logic [7:0] y0, y1);
		logic m1, m2;
		if (cfg[1:0] == 2'h1) begin
			m1 = eq(y0, rxa[31:24], mk[15:8]);
			m2 = eq(y0, rxa[15:8], mk[31:24]);
		end else if (cfg[2]) begin
			m1 = eq(y0, rxa[31:24], mk[15:8] | {6'h00, cfg[1:0] == 2'h0, 1'h0})
				&& eq(y1, rxa[23:16], mk[7:0]);
			m2 = eq(y0, rxa[15:8], mk[31:24]) && eq(y1, rxa[7:0], mk[23:16]);
		end else begin
			m1 = eq(y0, rxa[23:16], mk[7:0]);
			m2 = eq(y0, rxa[7:0], mk[23:16]);
		end
		return {m1 | m2, m2 & ~m1, cfg[2] ? y0[1] : m1 ^ rxa[25]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task results();
		if (err_total == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task lim(input integer n);
		if (n >= 50) begin
			err_total = err_total + 1;
			results();
		end
	endtask
	task axi_write(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		integer n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n = n + 1;
		end while (!bvalid && n < 50);
		bready <= 1'h0;
		lim(n);
		chk(bresp, er);
	endtask
	task axi_read(input logic [11:0] a);
		integer n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
			n = n + 1;
		end while (!rvalid && n < 50);
		rready <= 1'h0;
		rv = rdata;
		resp = rresp;
		lim(n);
	endtask
	task tx_pair();
		@(posedge aclk);
		tx_req <= 1'h1;
		tx_cmd <= 1'h1;
		@(posedge aclk);
		tx_cmd <= 1'h0;
		@(posedge aclk);
		tx_req <= 1'h0;
		if (cfg[1:0] == 2'h3) chk({tx_valid, tx_ins}, 2'h2);
		else chk({tx_valid, tx_ins, tx_two, tx_hi, tx_lo},
			{2'h3, tx_exp(1)});
		@(posedge aclk);
		if (cfg[1:0] == 2'h3) chk({tx_valid, tx_ins}, 2'h2);
		else chk({tx_valid, tx_ins, tx_two, tx_hi, tx_lo},
			{2'h3, tx_exp(0)});
	endtask
	task rx_one(input logic [7:0] y0, input logic [7:0] y1);
		u_peer.send(y0, y1);
		@(posedge aclk);
		e = rx_exp(y0, y1);
		if (cfg[1:0] == 2'h3) chk(rx_acc, 1'h1);
		else chk({rx_acc, rx_sec, rx_st[3:1]},
			{e[2:1], 1'h1, e[1], e[2]});
		if (e[2] && cfg[1:0] != 2'h3 && cfg[1:0] != 2'h1)
			chk(rx_st[0], e[0]);
	endtask
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, tx_req} = 7'h00;
		{awaddr, araddr, wdata, tx_cmd} = 57'h0;
		wstrb = 4'hF;
		seed = 32'h841A087D;
		err_total = 0;
		compares = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		axi_read(12'h134);
		chk(rv, 32'h0);
		axi_read(12'h138);
		chk(rv, 32'h0);
		axi_write(12'h200, rnd(), 2'h2);
		axi_read(12'h200);
		chk(rv, 32'h0);
		chk(resp, 2'h2);
		// ----------------------------------------
		// byte strobes: only the enabled lane lands
		// ----------------------------------------
		@(posedge aclk);
		wstrb <= 4'h2;
		axi_write(12'h134, 32'h12345678, 2'h0);
		axi_read(12'h134);
		chk(rv, 32'h00005600);
		wstrb <= 4'hF;
		for (i = 0; i < 40; i = i + 1) begin
			r = rnd();
			cfg = {29'h0, r[0], i[1:0]};
			txa = rnd() & 32'h0000FFFF;
			if (cfg[2]) txa[1] = 1'h0;
			rxa = rnd();
			if (cfg[2:0] == 3'h0) rxa[31:24] = 8'h00;
			mk = (i % 5 == 0) ? 32'hFFFFFFFF : rnd() & rnd() & rnd();
			axi_write(12'h100, cfg, 2'h0);
			axi_write(12'h134, txa | (rnd() & 32'hFFFF0000), 2'h0);
			axi_write(12'h138, rxa, 2'h0);
			axi_write(12'h13C, mk, 2'h0);
			axi_read(12'h134);
			chk(rv, txa);
			axi_read(12'h138);
			chk(rv, rxa);
			tx_pair();
			for (j = 0; j < 6; j = j + 1) begin
				r = rnd();
				x1 = r[1] ? rxa[23:16] : rxa[7:0];
				x0 = (cfg[2] || cfg[1:0] == 2'h1) ? (r[1] ? rxa[31:24] : rxa[15:8]) : x1;
				x0 = r[0] ? x0 ^ (r[15:8] & r[23:16]) : r[15:8];
				rx_one(x0, r[2] ? x1 : r[31:24]);
			end
		end
		results();
	end
endmodule
bind hdlc_address_unit hdlc_address_unit_checker u_chk (
	.aclk(aclk), .aresetn(aresetn), .tx_req(tx_req),
	.tx_is_command(tx_is_command), .tx_addr_valid(tx_addr_valid),
	.tx_addr_insert(tx_addr_insert), .tx_addr_two(tx_addr_two),
	.tx_addr_high(tx_addr_high), .tx_addr_low(tx_addr_low),
	.rx_addr_valid(rx_addr_valid), .rx_result_valid(rx_result_valid),
	.rx_accept(rx_accept), .rx_match_second(rx_match_second),
	.rx_status_byte(rx_status_byte)
);
`default_nettype wire
